// ---- hw/mbm_pkg.sv ----
// constants for the multicart bank mapper
package mbm_pkg;

  // decoded cpu address windows (inclusive)
  localparam logic [15:0] MBM_CFG_LO = 16'hff80;
  localparam logic [15:0] MBM_CFG_HI = 16'hff9f;
  localparam logic [15:0] MBM_LOCK_LO = 16'hffc0;
  localparam logic [15:0] MBM_LOCK_HI = 16'hffdf;
  localparam logic [15:0] MBM_BANK_LO = 16'hffe8;
  localparam logic [15:0] MBM_BANK_HI = 16'hfff7;

  // page_configuration fields
  localparam int MBM_CFG_MIRROR_BIT = 7;
  localparam int MBM_CFG_PAGE64_BIT = 6;
  localparam int MBM_CFG_DISABLE_BIT = 5;
  localparam int MBM_CFG_OUTER_MSB = 5;
  localparam int MBM_CFG_OUTER_LSB = 0;

  // inner_bank_select fields
  localparam int MBM_BANK_CHR_MSB = 6;
  localparam int MBM_BANK_CHR_MID = 5;
  localparam int MBM_BANK_CHR_LSB = 4;
  localparam int MBM_BANK_PRG_BIT = 0;

  // lockout_control fields
  localparam int MBM_LOCK_RST_BIT = 1;
  localparam int MBM_LOCK_OUT_BIT = 0;

  // reset values
  localparam logic [7:0] MBM_CFG_RESET = 8'h00;
  localparam logic [7:0] MBM_BANK_RESET = 8'h00;
  localparam logic [1:0] MBM_LOCK_RESET = 2'h0;

  // widths
  localparam int MBM_ADDR_W = 16;
  localparam int MBM_DATA_W = 8;
  localparam int MBM_PRG_BANK_W = 6;
  localparam int MBM_CHR_BANK_W = 8;
  localparam int MBM_SYNC_W = MBM_ADDR_W + MBM_DATA_W + 3;

endpackage : mbm_pkg

// ---- hw/mbm_mapper.sv ----
// multicart bank mapper: cpu-side register decode and rom bank outputs
`timescale 1ns/10ps
`default_nettype none

module mbm_mapper
  import mbm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic console_reset_n,
  input wire logic cpu_m2,
  input wire logic cpu_rom_select_n,
  input wire logic [MBM_ADDR_W-1:0] cpu_addr,
  input wire logic [MBM_DATA_W-1:0] cpu_data,
  output logic [MBM_PRG_BANK_W-1:0] prg_rom_bank,
  output logic [MBM_CHR_BANK_W-1:0] character_rom_bank,
  output logic rom_disable,
  output logic mirror_horizontal,
  output logic lockout_chip_reset_out,
  output logic lockout_chip_data_out,
  output logic [MBM_DATA_W-1:0] page_configuration_q
);

  // two-stage synchroniser for the console reset and cpu bus pin inputs
  logic [MBM_SYNC_W-1:0] sync1_reg;
  logic [MBM_SYNC_W-1:0] sync2_reg;
  logic [MBM_SYNC_W-1:0] sync1_next;
  logic [MBM_SYNC_W-1:0] sync2_next;

  // bus-cycle capture
  logic m2_prev_reg;
  logic m2_prev_next;
  logic [MBM_ADDR_W-1:0] hold_addr_reg;
  logic [MBM_ADDR_W-1:0] hold_addr_next;
  logic [MBM_DATA_W-1:0] hold_data_reg;
  logic [MBM_DATA_W-1:0] hold_data_next;
  logic hold_rom_reg;
  logic hold_rom_next;

  // mapper registers
  logic [MBM_DATA_W-1:0] page_configuration_reg;
  logic [MBM_DATA_W-1:0] page_configuration_next;
  logic [MBM_DATA_W-1:0] inner_bank_select_reg;
  logic [MBM_DATA_W-1:0] inner_bank_select_next;
  logic [1:0] lockout_control_reg;
  logic [1:0] lockout_control_next;

  // registered outputs
  logic [MBM_PRG_BANK_W-1:0] prg_bank_reg;
  logic [MBM_PRG_BANK_W-1:0] prg_bank_next;
  logic [MBM_CHR_BANK_W-1:0] chr_bank_reg;
  logic [MBM_CHR_BANK_W-1:0] chr_bank_next;
  logic rom_disable_reg;
  logic rom_disable_next;
  logic mirror_reg;
  logic mirror_next;

  // synchronised views, second stage only
  logic s_console_reset_n;
  logic s_m2;
  logic s_rom_select_n;
  logic [MBM_ADDR_W-1:0] s_addr;
  logic [MBM_DATA_W-1:0] s_data;

  logic access_done;
  logic hit_cfg;
  logic hit_lock;
  logic hit_bank;
  logic cfg_locked;
  logic page64;

  assign {s_console_reset_n, s_m2, s_rom_select_n, s_addr, s_data} = sync2_reg;

  always_comb begin
    sync1_next = {console_reset_n, cpu_m2, cpu_rom_select_n, cpu_addr, cpu_data};
    sync2_next = sync1_reg;
  end

  // address and data are captured while m2 is high and held after it falls; the falling edge ends the access,
  // so reads and writes are treated identically
  always_comb begin
    m2_prev_next = s_m2;
    hold_addr_next = hold_addr_reg;
    hold_data_next = hold_data_reg;
    hold_rom_next = hold_rom_reg;
    if (s_m2) begin
      hold_addr_next = s_addr;
      hold_data_next = s_data;
      hold_rom_next = ~s_rom_select_n;
    end
  end

  assign access_done = m2_prev_reg & ~s_m2 & hold_rom_reg;

  // each window is a full range compare, so no address hits two registers
  always_comb begin
    hit_cfg = (hold_addr_reg >= MBM_CFG_LO) && (hold_addr_reg <= MBM_CFG_HI);
    hit_lock = (hold_addr_reg >= MBM_LOCK_LO) && (hold_addr_reg <= MBM_LOCK_HI);
    hit_bank = (hold_addr_reg >= MBM_BANK_LO) && (hold_addr_reg <= MBM_BANK_HI);
  end

  assign cfg_locked = (page_configuration_reg != MBM_CFG_RESET);
  assign page64 = page_configuration_reg[MBM_CFG_PAGE64_BIT];

  // data driven on a write is trusted to equal the rom byte; no contention check here
  always_comb begin
    page_configuration_next = page_configuration_reg;
    inner_bank_select_next = inner_bank_select_reg;
    // console reset leaves the lockout register alone
    lockout_control_next = lockout_control_reg;
    if (!s_console_reset_n) begin
      page_configuration_next = MBM_CFG_RESET;
      inner_bank_select_next = MBM_BANK_RESET;
    end else if (access_done) begin
      if (hit_cfg && !cfg_locked) begin
        page_configuration_next = hold_data_reg;
      end
      if (hit_bank) begin
        inner_bank_select_next = hold_data_reg;
      end
      if (hit_lock && cfg_locked) begin
        lockout_control_next = {hold_data_reg[MBM_LOCK_RST_BIT], hold_data_reg[MBM_LOCK_OUT_BIT]};
      end
    end
  end

  always_comb begin
    if (page64) begin
      prg_bank_next = {page_configuration_reg[MBM_CFG_OUTER_MSB:MBM_CFG_OUTER_LSB + 1],
                       inner_bank_select_reg[MBM_BANK_PRG_BIT]};
      chr_bank_next = {page_configuration_reg[MBM_CFG_OUTER_MSB:MBM_CFG_OUTER_LSB + 1],
                       inner_bank_select_reg[MBM_BANK_CHR_MSB:MBM_BANK_CHR_LSB]};
    end else begin
      prg_bank_next = page_configuration_reg[MBM_CFG_OUTER_MSB:MBM_CFG_OUTER_LSB];
      chr_bank_next = {page_configuration_reg[MBM_CFG_OUTER_MSB:MBM_CFG_OUTER_LSB],
                       inner_bank_select_reg[MBM_BANK_CHR_MID:MBM_BANK_CHR_LSB]};
    end
    rom_disable_next = page_configuration_reg[MBM_CFG_DISABLE_BIT];
    mirror_next = page_configuration_reg[MBM_CFG_MIRROR_BIT];
  end

  // synchroniser stages freeze with clk_en as well
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else if (clk_en) begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      m2_prev_reg <= 1'b0;
      hold_addr_reg <= '0;
      hold_data_reg <= '0;
      hold_rom_reg <= 1'b0;
    end else if (clk_en) begin
      m2_prev_reg <= m2_prev_next;
      hold_addr_reg <= hold_addr_next;
      hold_data_reg <= hold_data_next;
      hold_rom_reg <= hold_rom_next;
    end
  end

  // rst_n is power-up: of the two resets, it alone clears the lockout register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      page_configuration_reg <= MBM_CFG_RESET;
      inner_bank_select_reg <= MBM_BANK_RESET;
      lockout_control_reg <= MBM_LOCK_RESET;
    end else if (clk_en) begin
      page_configuration_reg <= page_configuration_next;
      inner_bank_select_reg <= inner_bank_select_next;
      lockout_control_reg <= lockout_control_next;
    end
  end

  // bank, disable and mirror outputs lag the mapper registers by one edge so every pin is a flop
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prg_bank_reg <= '0;
      chr_bank_reg <= '0;
      rom_disable_reg <= 1'b0;
      mirror_reg <= 1'b0;
    end else if (clk_en) begin
      prg_bank_reg <= prg_bank_next;
      chr_bank_reg <= chr_bank_next;
      rom_disable_reg <= rom_disable_next;
      mirror_reg <= mirror_next;
    end
  end

  assign prg_rom_bank = prg_bank_reg;
  assign character_rom_bank = chr_bank_reg;
  assign rom_disable = rom_disable_reg;
  assign mirror_horizontal = mirror_reg;
  assign lockout_chip_reset_out = lockout_control_reg[MBM_LOCK_RST_BIT];
  assign lockout_chip_data_out = lockout_control_reg[MBM_LOCK_OUT_BIT];
  assign page_configuration_q = page_configuration_reg;

endmodule : mbm_mapper

`default_nettype wire

// ---- verification/mbm_mapper_properties.sv ----
// port-level assertions for the bank mapper
`timescale 1ns/10ps
`default_nettype none
module mbm_mapper_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic console_reset_n,
  input wire logic [5:0] prg_rom_bank,
  input wire logic [7:0] character_rom_bank,
  input wire logic rom_disable,
  input wire logic mirror_horizontal,
  input wire logic lockout_chip_reset_out,
  input wire logic lockout_chip_data_out,
  input wire logic [7:0] page_configuration_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_dis; rom_disable == $past(page_configuration_q[5]); endproperty
  property p_mir; mirror_horizontal == $past(page_configuration_q[7]); endproperty
  property p_prg32; !page_configuration_q[6] |=> prg_rom_bank == $past(page_configuration_q[5:0]); endproperty
  property p_prg64; page_configuration_q[6] |=> prg_rom_bank[5:1] == $past(page_configuration_q[5:1]); endproperty
  property p_chr32; !page_configuration_q[6] |=> character_rom_bank[7:2] == $past(page_configuration_q[5:0]);
  endproperty
  // three sampled highs: nothing left in the synchroniser can clear on the next edge
  property p_hold; page_configuration_q != 8'h00 && console_reset_n && $past(console_reset_n) &&
    $past(console_reset_n, 2) |=> $stable(page_configuration_q); endproperty
  property p_clear; !console_reset_n [*4] |-> page_configuration_q == 8'h00 ##1
    (prg_rom_bank == 6'h00 && character_rom_bank == 8'h00); endproperty
  property p_lock; page_configuration_q == 8'h00 |=>
    $stable({lockout_chip_reset_out, lockout_chip_data_out}); endproperty
  a_dis: assert property (p_dis) else $error("rom disable wrong");
  a_mir: assert property (p_mir) else $error("mirroring wrong");
  a_prg32: assert property (p_prg32) else $error("small page prg wrong");
  a_prg64: assert property (p_prg64) else $error("large page prg wrong");
  a_chr32: assert property (p_chr32) else $error("chr outer bank wrong");
  a_hold: assert property (p_hold) else $error("config changed when locked");
  a_clear: assert property (p_clear) else $error("console reset did not clear");
  a_lock: assert property (p_lock) else $error("lockout moved while unconfigured");
  c_big: cover property (page_configuration_q[6]);
  c_lock: cover property (lockout_chip_reset_out);
  c_dis: cover property (rom_disable);
endmodule : mbm_mapper_checker
bind mbm_mapper mbm_mapper_checker u_chk (
  .mclk(mclk),
  .rst_n(rst_n),
  .console_reset_n(console_reset_n),
  .prg_rom_bank(prg_rom_bank),
  .character_rom_bank(character_rom_bank),
  .rom_disable(rom_disable),
  .mirror_horizontal(mirror_horizontal),
  .lockout_chip_reset_out(lockout_chip_reset_out),
  .lockout_chip_data_out(lockout_chip_data_out),
  .page_configuration_q(page_configuration_q)
);
`default_nettype wire

// ---- verification/mbm_rom_model.sv ----
// program rom stand-in driving its byte onto the cpu data bus
`timescale 1ns/10ps
`default_nettype none
module mbm_rom_model (
  input wire logic [15:0] cpu_addr,
  input wire logic [5:0] prg_rom_bank,
  input wire logic rom_disable,
  output logic [7:0] rom_data
);
  // deselected chip must not look like valid data
  always_comb rom_data = rom_disable ? ~cpu_addr[7:0] : cpu_addr[7:0] ^ {2'h0, prg_rom_bank};
endmodule : mbm_rom_model
`default_nettype wire

// ---- verification/mbm_mapper_test.sv ----
// self-checking bench for the bank mapper
`timescale 1ns/10ps
`default_nettype none
module mbm_mapper_test;
  logic mclk, rst_n, console_reset_n, cpu_m2, cpu_rom_select_n, rd;
  logic clk_en = 1'b1;
  logic [15:0] cpu_addr;
  logic [7:0] wd, rom_data, character_rom_bank, page_configuration_q;
  logic [5:0] prg_rom_bank;
  logic rom_disable, mirror_horizontal, lockout_chip_reset_out, lockout_chip_data_out;
  wire logic [7:0] cpu_data = rd ? rom_data : wd;
  wire logic [7:0] prg = {2'h0, prg_rom_bank};
  wire logic [7:0] st = {4'h0, rom_disable, mirror_horizontal, lockout_chip_reset_out, lockout_chip_data_out};
  int n_errors = 0;
  int samples_checked = 0;
  mbm_mapper dut (
    .mclk(mclk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .console_reset_n(console_reset_n),
    .cpu_m2(cpu_m2),
    .cpu_rom_select_n(cpu_rom_select_n),
    .cpu_addr(cpu_addr),
    .cpu_data(cpu_data),
    .prg_rom_bank(prg_rom_bank),
    .character_rom_bank(character_rom_bank),
    .rom_disable(rom_disable),
    .mirror_horizontal(mirror_horizontal),
    .lockout_chip_reset_out(lockout_chip_reset_out),
    .lockout_chip_data_out(lockout_chip_data_out),
    .page_configuration_q(page_configuration_q)
  );
  mbm_rom_model rom (
    .cpu_addr(cpu_addr),
    .prg_rom_bank(prg_rom_bank),
    .rom_disable(rom_disable),
    .rom_data(rom_data)
  );
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  // m2 high then low for long enough that the synchroniser sees both
  task acc(input logic [15:0] a, input logic [7:0] d, input logic r);
    @(negedge mclk);
    cpu_addr = a;
    wd = d;
    rd = r;
    cpu_rom_select_n = 1'b0;
    cpu_m2 = 1'b1;
    repeat (4) @(negedge mclk);
    cpu_m2 = 1'b0;
    repeat (6) @(negedge mclk);
    cpu_rom_select_n = 1'b1;
    rd = 1'b0;
  endtask : acc
  task pulse_console;
    @(negedge mclk) console_reset_n = 1'b0;
    repeat (6) @(negedge mclk);
    console_reset_n = 1'b1;
  endtask : pulse_console
  task t_config;
    chk("cfg", page_configuration_q, 8'h00);
    acc(16'hffa0, 8'h41, 1'b0);
    chk("cfg", page_configuration_q, 8'h00);
    acc(16'hff9f, 8'h4b, 1'b0);
    chk("prg", prg, 8'h0a);
    chk("chr", character_rom_bank, 8'h28);
    acc(16'hff85, 8'h00, 1'b0);
    chk("cfg", page_configuration_q, 8'h4b);
    acc(16'hffe8, 8'h71, 1'b0);
    chk("chr", character_rom_bank, 8'h2f);
    chk("prg", prg, 8'h0b);
    acc(16'hfff8, 8'h00, 1'b0);
    chk("chr", character_rom_bank, 8'h2f);
    acc(16'hffc0, 8'h02, 1'b0);
    chk("st", st, 8'h02);
  endtask : t_config
  task t_console;
    pulse_console;
    chk("cfg", page_configuration_q, 8'h00);
    chk("chr", character_rom_bank, 8'h00);
    chk("st", st, 8'h02);
    acc(16'hffdf, 8'h00, 1'b0);
    chk("st", st, 8'h02);
    acc(16'hff80, 8'h20, 1'b0);
    chk("st", st, 8'h0a);
  endtask : t_console
  task t_read;
    pulse_console;
    acc(16'hff81, 8'h00, 1'b1);
    chk("st", st, 8'h06);
    chk("prg", prg, 8'h01);
    acc(16'hfff7, 8'h71, 1'b0);
    chk("chr", character_rom_bank, 8'h07);
    chk("prg", prg, 8'h01);
  endtask : t_read
  task stop_test;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    rst_n = 1'b0;
    console_reset_n = 1'b1;
    cpu_m2 = 1'b0;
    cpu_rom_select_n = 1'b1;
    rd = 1'b0;
    cpu_addr = 16'h0000;
    wd = 8'h00;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    t_config;
    t_console;
    t_read;
    stop_test;
  end
  initial begin
    repeat (3000) @(posedge mclk);
    n_errors++;
    stop_test;
  end
endmodule : mbm_mapper_test
`default_nettype wire
